// ### core/osc_clock_select.sv
`timescale 1ns/1ps
`default_nettype none

module osc_clock_select
  import osc_sel_pkg::*;
#(
  parameter int FAIL_CYCLES = FAIL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cfg_type config_word_one,
  input wire logic osc_pin_in,
  input wire logic fast_osc_in,
  input wire logic fast_osc_ready,
  input wire logic slow_osc_in,
  input wire logic slow_osc_ready,
  input wire logic power_up_done,
  input wire logic sleep_req,
  output logic sys_clk,
  output logic divided_clock_output,
  output logic osc_in_gpio,
  output logic osc_out_gpio,
  output gain_type amp_gain,
  output logic cpu_hold,
  output logic clock_fail
);

  logic [2:0] internal_freq_select_r;
  logic scs_r;
  logic startup_timeout_status_r;
  logic hts_r;
  logic lts_r;
  logic cur_int_r;
  logic [2:0] cur_internal_freq_select_r;
  logic pend_int_r;
  logic [2:0] pend_internal_freq_select_r;
  logic [POST_W-1:0] post_cnt_r;
  logic fast_prev_r;
  logic ext_prev_r;
  logic sleep_prev_r;
  logic [OST_W-1:0] ost_cnt_r;
  logic ost_done_r;
  logic [CNT_W-1:0] warm_cnt_r;
  logic warm_done_r;
  logic [CNT_W-1:0] fail_cnt_r;
  logic clock_fail_r;
  logic cpu_hold_r;
  logic sys_clk_r;
  logic sys_prev_r;
  logic [1:0] div_cnt_r;
  logic div_clk_r;
  logic osc_in_gpio_r;
  logic osc_out_gpio_r;
  gain_type amp_gain_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  logic crystal;
  logic int_mode;
  logic want_int;
  logic tgt_ready;
  logic sw_req;
  logic sw_busy;
  logic sw_hold;
  logic sw_swap;
  logic cur_lvl;
  logic new_lvl;
  logic ext_rise;
  logic wake;
  logic apb_write;
  logic clk_out_mode;
  osc_ctrl_type ctrl_view;

  // Level of the internal clock for a given frequency select
  function automatic logic int_level(input logic [2:0] sel, input logic [POST_W-1:0] cnt,
                                     input logic fast, input logic slow);
    logic [2:0] idx;
    idx = 3'(INTERNAL_FREQ_SELECT_TOP - sel - INTERNAL_FREQ_SELECT_ONE);
    if (sel == INTERNAL_FREQ_SELECT_SLOW) int_level = slow;
    else if (sel == INTERNAL_FREQ_SELECT_TOP) int_level = fast;
    else int_level = cnt[idx];
  endfunction : int_level

  // Mode decode from the configuration word
  assign crystal = (config_word_one.mode == MODE_LP) || (config_word_one.mode == MODE_XT) ||
                   (config_word_one.mode == MODE_HS);
  assign int_mode = (config_word_one.mode == MODE_INT_IO) || (config_word_one.mode == MODE_INT_OUT);
  assign ext_rise = osc_pin_in && !ext_prev_r;
  assign wake = sleep_prev_r && !sleep_req;
  // Only these modes put the divided clock on the second pin
  assign clk_out_mode = (config_word_one.mode == MODE_RC) || (config_word_one.mode == MODE_INT_OUT);

  // Target source: software select, fail-safe fallback, or start-up on internal
  assign want_int = scs_r || clock_fail_r || int_mode || (crystal && !ost_done_r);
  assign tgt_ready = want_int ? ((internal_freq_select_r == INTERNAL_FREQ_SELECT_SLOW) ? slow_osc_ready : fast_osc_ready) : ost_done_r;
  assign sw_req = tgt_ready && ((want_int != cur_int_r) || (want_int && (internal_freq_select_r != cur_internal_freq_select_r)));
  // A failed outside clock may have stopped high, so it counts as low for the handover
  assign cur_lvl = cur_int_r ? int_level(cur_internal_freq_select_r, post_cnt_r, fast_osc_in, slow_osc_in) :
                   (osc_pin_in && !clock_fail_r);
  assign new_lvl = pend_int_r ? int_level(pend_internal_freq_select_r, post_cnt_r, fast_osc_in, slow_osc_in) : osc_pin_in;

  clock_handover u_handover (
    .pclk(pclk),
    .presetn(presetn),
    .req(sw_req),
    .cur_lvl(cur_lvl),
    .new_lvl(new_lvl),
    .busy(sw_busy),
    .hold(sw_hold),
    .swap(sw_swap)
  );

  // Fast oscillator postscaler, counts its rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_r <= '0;
      fast_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
      sleep_prev_r <= 1'b0;
    end else begin
      fast_prev_r <= fast_osc_in;
      ext_prev_r <= osc_pin_in;
      sleep_prev_r <= sleep_req;
      if (fast_osc_in && !fast_prev_r) post_cnt_r <= post_cnt_r + 1'b1;
    end
  end

  // Connected source bookkeeping, latched at request and swapped on join
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_int_r <= 1'b1;
      cur_internal_freq_select_r <= INTERNAL_FREQ_SELECT_RESET;
      pend_int_r <= 1'b1;
      pend_internal_freq_select_r <= INTERNAL_FREQ_SELECT_RESET;
    end else begin
      if (!sw_busy && sw_req) begin
        pend_int_r <= want_int;
        pend_internal_freq_select_r <= internal_freq_select_r;
      end
      if (sw_swap) begin
        cur_int_r <= pend_int_r;
        cur_internal_freq_select_r <= pend_internal_freq_select_r;
      end
    end
  end

  // System clock: parked low during handover, else follows the connected source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_r <= 1'b0;
    end else begin
      sys_clk_r <= !sw_hold && cur_lvl;
    end
  end

  // Start-up oscillation counter for crystal modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_r <= '0;
      ost_done_r <= 1'b0;
    end else if (!crystal) begin
      ost_cnt_r <= '0;
      ost_done_r <= 1'b1;
    end else if (wake || sleep_req || !power_up_done) begin
      ost_cnt_r <= '0;
      ost_done_r <= 1'b0;
    end else if (!ost_done_r && ext_rise) begin
      ost_cnt_r <= ost_cnt_r + 1'b1;
      if (ost_cnt_r == OST_COUNT - 1'b1) ost_done_r <= 1'b1;
    end
  end

  // Warm-up delay when starting on an internal oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt_r <= '0;
      warm_done_r <= 1'b0;
    end else if (wake || sleep_req || !power_up_done) begin
      warm_cnt_r <= '0;
      warm_done_r <= 1'b0;
    end else if (!warm_done_r) begin
      if (!want_int) begin
        warm_done_r <= 1'b1;
      end else if (tgt_ready) begin
        warm_cnt_r <= warm_cnt_r + 1'b1;
        if (warm_cnt_r == CNT_W'(WARMUP_CYC - 1)) warm_done_r <= 1'b1;
      end
    end
  end

  // Execution hold while sleeping, warming or, without two-speed start-up, counting oscillations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_hold_r <= 1'b1;
    end else begin
      cpu_hold_r <= sleep_req || !power_up_done || !warm_done_r ||
                    (crystal && !config_word_one.two_speed && !ost_done_r);
    end
  end

  // Fail-safe monitor on external sources, counts cycles without an input edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_cnt_r <= '0;
      clock_fail_r <= 1'b0;
    end else if (!config_word_one.failsafe || int_mode || !ost_done_r || sleep_req ||
                 (osc_pin_in != ext_prev_r)) begin
      fail_cnt_r <= '0;
    end else if (!clock_fail_r) begin
      fail_cnt_r <= fail_cnt_r + 1'b1;
      if (fail_cnt_r == CNT_W'(FAIL_CYCLES - 1)) clock_fail_r <= 1'b1;
    end
  end

  // Status bits track the connected source; the slow stable bit is also set while fail-safe is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_timeout_status_r <= 1'b0;
      hts_r <= 1'b0;
      lts_r <= 1'b0;
    end else begin
      startup_timeout_status_r <= !cur_int_r;
      hts_r <= fast_osc_ready && cur_int_r && (cur_internal_freq_select_r != INTERNAL_FREQ_SELECT_SLOW);
      lts_r <= slow_osc_ready && ((cur_int_r && (cur_internal_freq_select_r == INTERNAL_FREQ_SELECT_SLOW)) ||
               config_word_one.failsafe);
    end
  end

  // Fosc/4 on the output pin, toggled every second system clock rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_prev_r <= 1'b0;
      div_cnt_r <= '0;
      div_clk_r <= 1'b0;
    end else begin
      sys_prev_r <= sys_clk_r;
      if (!clk_out_mode) begin
        div_clk_r <= 1'b0;
      end else if (sys_clk_r && !sys_prev_r) begin
        div_cnt_r <= div_cnt_r + 1'b1;
        if (div_cnt_r[0]) div_clk_r <= !div_clk_r;
      end
    end
  end

  // Pin roles and amplifier gain from the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_in_gpio_r <= 1'b0;
      osc_out_gpio_r <= 1'b0;
      amp_gain_r <= GAIN_OFF;
    end else begin
      osc_in_gpio_r <= int_mode;
      osc_out_gpio_r <= (config_word_one.mode == MODE_EC) || (config_word_one.mode == MODE_RC_IO) ||
                        (config_word_one.mode == MODE_INT_IO);
      case (config_word_one.mode)
        MODE_LP: amp_gain_r <= GAIN_LOW;
        MODE_XT: amp_gain_r <= GAIN_MED;
        MODE_HS: amp_gain_r <= GAIN_HIGH;
        default: amp_gain_r <= GAIN_OFF;
      endcase
    end
  end

  // Control register read view
  always_comb begin
    ctrl_view = '0;
    ctrl_view.internal_freq_select = internal_freq_select_r;
    ctrl_view.startup_timeout_status = startup_timeout_status_r;
    ctrl_view.fast_osc_stable = hts_r;
    ctrl_view.slow_osc_stable = lts_r;
    ctrl_view.system_clock_select = scs_r;
  end

  assign apb_write = psel && penable && pready_r && pwrite;

  // Writable control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_freq_select_r <= INTERNAL_FREQ_SELECT_RESET;
      scs_r <= 1'b0;
    end else if (apb_write && (paddr == CTRL_OFFSET)) begin
      internal_freq_select_r <= pwdata[$bits(ctrl_view) - 2 -: 3];
      scs_r <= pwdata[0];
    end
  end

  // APB slave: one wait-free access phase, answer prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (psel && !penable && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= (paddr != CTRL_OFFSET) && (paddr != STAT_OFFSET);
      prdata_r <= '0;
      if (!pwrite && (paddr == CTRL_OFFSET)) prdata_r <= {24'h000000, ctrl_view};
      if (!pwrite && (paddr == STAT_OFFSET)) begin
        prdata_r[STAT_FAIL_BIT] <= clock_fail_r;
        prdata_r[STAT_HOLD_BIT] <= cpu_hold_r;
        prdata_r[STAT_OST_BIT] <= ost_done_r;
      end
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sys_clk = sys_clk_r;
  assign divided_clock_output = div_clk_r;
  assign osc_in_gpio = osc_in_gpio_r;
  assign osc_out_gpio = osc_out_gpio_r;
  assign amp_gain = amp_gain_r;
  assign cpu_hold = cpu_hold_r;
  assign clock_fail = clock_fail_r;

  a_ost_full_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ost_done_r) && crystal |-> $past(ost_cnt_r) == OST_COUNT - 1'b1)
    else $error("start-up counter finished early");

  a_hold_during_ost: assert property (@(posedge pclk) disable iff (!presetn)
    crystal && !config_word_one.two_speed && !ost_done_r |=> cpu_hold_r)
    else $error("execution released while counting");

  a_ec_skips_ost: assert property (@(posedge pclk) disable iff (!presetn)
    config_word_one.mode == MODE_EC |=> ost_done_r && osc_out_gpio_r)
    else $error("external clock mode still waits or holds pin");

  a_startup_timeout_status_internal: assert property (@(posedge pclk) disable iff (!presetn)
    cur_int_r && $past(cur_int_r) |-> !startup_timeout_status_r)
    else $error("start-up status set while on internal oscillator");

  a_fail_fallback: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(clock_fail_r) && tgt_ready |-> ##[1:1000] cur_int_r)
    else $error("no fallback to internal after clock failure");

  a_gain_mode: assert property (@(posedge pclk) disable iff (!presetn)
    config_word_one.mode == MODE_LP ##1 config_word_one.mode == MODE_LP |-> amp_gain_r == GAIN_LOW)
    else $error("low-power crystal mode without low gain");

  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    apb_write && paddr == CTRL_OFFSET |=> internal_freq_select_r == $past(pwdata[6:4]) && scs_r == $past(pwdata[0]))
    else $error("control write not stored");

  a_fast_stable: assert property (@(posedge pclk) disable iff (!presetn)
    hts_r |-> $past(fast_osc_ready) && $past(cur_internal_freq_select_r) != INTERNAL_FREQ_SELECT_SLOW)
    else $error("fast stable bit without stable oscillator");

  a_slow_stable: assert property (@(posedge pclk) disable iff (!presetn)
    lts_r |-> $past(slow_osc_ready))
    else $error("slow stable bit without stable oscillator");

  a_park_low: assert property (@(posedge pclk) disable iff (!presetn)
    sw_hold |=> !sys_clk_r)
    else $error("system clock high while parked");

endmodule : osc_clock_select

`default_nettype wire

// ### core/osc_sel_pkg.sv
package osc_sel_pkg;

  // Register map and bus timing
  localparam int CLK_HZ = 10_000_000;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h6;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_SLOW = 3'h0;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_TOP = 3'h7;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_ONE = 3'h1;

  // Status register bit positions
  localparam int STAT_FAIL_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_OST_BIT = 2;

  // Counts and times
  localparam int POST_W = 6;
  localparam int OST_W = 11;
  localparam logic [10:0] OST_COUNT = 11'h400;
  localparam int WARMUP_NS = 1000;
  localparam int WARMUP_CYC = (WARMUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int FAIL_NS = 100_000;
  localparam int FAIL_CYC = FAIL_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int CNT_W = 12;

  // Clock source modes from the non-volatile configuration
  typedef enum logic [2:0] {
    MODE_LP = 3'b000,
    MODE_XT = 3'b001,
    MODE_HS = 3'b010,
    MODE_EC = 3'b011,
    MODE_INT_IO = 3'b100,
    MODE_INT_OUT = 3'b101,
    MODE_RC_IO = 3'b110,
    MODE_RC = 3'b111
  } osc_mode_type;

  // Crystal amplifier gain
  typedef enum logic [1:0] {
    GAIN_OFF = 2'b00,
    GAIN_LOW = 2'b01,
    GAIN_MED = 2'b10,
    GAIN_HIGH = 2'b11
  } gain_type;

  // Handover sequencer states
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT_LOW = 2'b01,
    SW_HOLD = 2'b10
  } sw_state_type;

  // Configuration word fields
  typedef struct packed {
    osc_mode_type mode;
    logic two_speed;
    logic failsafe;
  } cfg_type;

  // Control register layout
  typedef struct packed {
    logic unused;
    logic [2:0] internal_freq_select;
    logic startup_timeout_status;
    logic fast_osc_stable;
    logic slow_osc_stable;
    logic system_clock_select;
  } osc_ctrl_type;

endpackage : osc_sel_pkg

// ### core/clock_handover.sv
`timescale 1ns/1ps
`default_nettype none

module clock_handover
  import osc_sel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic cur_lvl,
  input wire logic new_lvl,
  output logic busy,
  output logic hold,
  output logic swap
);

  sw_state_type state_r;
  logic new_prev_r;

  // Previous level of the incoming clock for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_prev_r <= 1'b0;
    end else begin
      new_prev_r <= new_lvl;
    end
  end

  // Wait for low on the old clock, park low, join on rising edge of the new
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SW_IDLE;
    end else begin
      case (state_r)
        SW_IDLE: if (req) state_r <= SW_WAIT_LOW;
        SW_WAIT_LOW: if (!cur_lvl) state_r <= SW_HOLD;
        SW_HOLD: if (new_lvl && !new_prev_r) state_r <= SW_IDLE;
        default: state_r <= SW_IDLE;
      endcase
    end
  end

  assign busy = (state_r != SW_IDLE);
  assign hold = (state_r == SW_HOLD);
  assign swap = hold && new_lvl && !new_prev_r;

  a_swap_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
    swap |-> hold && new_lvl && !$past(new_lvl))
    else $error("handover joined new clock without a rising edge");

  a_hold_after_low: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hold) |-> !$past(cur_lvl))
    else $error("output parked before old clock was low");

endmodule : clock_handover

`default_nettype wire

// ### verif/osc_source.sv
`timescale 1ns/1ps
`default_nettype none

// Outside clock source on the oscillator input pin, prompt or slow
module osc_source #(
  parameter int HALF = 2
) (
  input wire logic pclk,
  input wire logic run,
  input wire logic slow,
  output logic osc_pin_in
);
  int cnt = 0;

  // Full logic-level swing while running; stands still once stopped
  always @(posedge pclk) begin
    if (run) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= (slow ? 2 * HALF : HALF)) begin
        cnt <= 0;
        osc_pin_in <= ~osc_pin_in;
      end
    end
  end

  initial osc_pin_in = 1'h0;
endmodule : osc_source

`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import osc_sel_pkg::*;
;
  localparam int FAILN = 20;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
  } exp_type;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] seed = 32'h00000021;
  logic [31:0] prdata;
  logic pready, pslverr, osc_pin_in, sys_clk, dco, in_io, out_io, cpu_hold, clock_fail;
  logic fast_osc_in = 1'h0;
  logic slow_osc_in = 1'h0;
  logic sleep_req = 1'h0;
  logic run = 1'h1;
  gain_type amp_gain;
  cfg_type cfg = '{MODE_INT_IO, 1'h0, 1'h0};
  exp_type expq[$];
  exp_type ex;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  osc_clock_select #(
    .FAIL_CYCLES(FAILN)
  ) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_word_one(cfg), .osc_pin_in(osc_pin_in), .fast_osc_in(fast_osc_in),
    .fast_osc_ready(1'h1), .slow_osc_in(slow_osc_in), .slow_osc_ready(1'h1),
    .power_up_done(1'h1), .sleep_req(sleep_req), .sys_clk(sys_clk),
    .divided_clock_output(dco), .osc_in_gpio(in_io), .osc_out_gpio(out_io),
    .amp_gain(amp_gain), .cpu_hold(cpu_hold), .clock_fail(clock_fail)
  );

  osc_source u_src (
    .pclk(pclk),
    .run(run),
    .slow(1'h0),
    .osc_pin_in(osc_pin_in)
  );

  // Clock generator
  always #50 pclk = ~pclk;

  // Internal oscillator levels and hang guard
  always @(posedge pclk) begin
    fast_osc_in <= ~fast_osc_in;
    cyc <= cyc + 1;
    if (cyc[1:0] == 2'h0) slow_osc_in <= ~slow_osc_in;
    if (cyc == 30000) begin
      fail("timeout");
      give_verdict();
    end
  end

  // Compare each completed read with the oldest noted expectation
  always @(posedge pclk) begin
    if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0) begin
      samples_checked++;
      if (expq.size() == 0) begin
        fail("read not expected");
      end else begin
        ex = expq.pop_front();
        if ((prdata & ex.m) !== (ex.d & ex.m) || pslverr !== ex.e) fail("read data");
      end
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic fail(input string s);
    error_cnt++;
    $display("ERROR at %0t: %s", $time, s);
  endtask : fail

  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string s);
    samples_checked++;
    if (got !== exp) fail(s);
  endtask : chk

  // One bus transfer: setup, then access until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
    expq.push_back('{d, m, e});
    apb(1'h0, a, 32'h00000000);
  endtask : rd

  // Read-only and unused bits get random values
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    seed = lfsr(seed);
    apb(1'h1, a, (seed & 32'hFFFFFF8E) | (d & 32'h00000071));
  endtask : wr

  task automatic do_reset(input osc_mode_type m, input logic ts, input logic fs);
    @(posedge pclk);
    presetn <= 1'h0;
    cfg <= '{m, ts, fs};
    run <= 1'h1;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
  endtask : do_reset

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    int n;
    int n2;
    logic prev;
    logic prev2;
    osc_mode_type md;
    do_reset(MODE_INT_IO, 1'h0, 1'h0);
    rd(CTRL_OFFSET, 32'h00000060, 32'hFFFFFFF9, 1'h0);
    rd(8'h08, 32'h00000000, 32'hFFFFFFFF, 1'h1);
    for (int k = 7; k >= 0; k--) begin
      wr(CTRL_OFFSET, {25'h0, k[2:0], 4'h0});
      repeat (300) @(posedge pclk);
      rd(CTRL_OFFSET, {25'h0, k[2:0], 1'h0, k != 0, k == 0, 1'h0}, 32'hFFFFFFFF, 1'h0);
    end
    wr(8'h08, 32'h00000070);
    rd(CTRL_OFFSET, 32'h00000002, 32'hFFFFFFFF, 1'h0);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      md = osc_mode_type'(m);
      do_reset(md, 1'h0, 1'h0);
      n = 0;
      n2 = 0;
      repeat (200) begin
        prev = dco;
        prev2 = sys_clk;
        @(posedge pclk);
        if (dco !== prev) n++;
        if (sys_clk !== prev2) n2++;
      end
      chk(n2 > 0, 1'h1, "system clock");
      chk(amp_gain, md == MODE_LP ? GAIN_LOW : md == MODE_XT ? GAIN_MED : md == MODE_HS ? GAIN_HIGH : GAIN_OFF,
          "gain");
      chk(out_io, md inside {MODE_EC, MODE_RC_IO, MODE_INT_IO}, "second pin");
      chk(in_io, md inside {MODE_INT_IO, MODE_INT_OUT}, "input pin");
      chk(n > 0, md inside {MODE_RC, MODE_INT_OUT}, "divided clock");
    end
    $display("test modes done");
    do_reset(MODE_XT, 1'h0, 1'h0);
    repeat (3900) @(posedge pclk);
    chk(cpu_hold, 1'h1, "held in count");
    repeat (300) @(posedge pclk);
    chk(cpu_hold, 1'h0, "count end");
    rd(STAT_OFFSET, 32'h00000004, 32'hFFFFFFFF, 1'h0);
    rd(CTRL_OFFSET, 32'h00000068, 32'hFFFFFFF9, 1'h0);
    sleep_req <= 1'h1;
    repeat (5) @(posedge pclk);
    sleep_req <= 1'h0;
    repeat (5) @(posedge pclk);
    chk(cpu_hold, 1'h1, "wake count");
    repeat (4300) @(posedge pclk);
    chk(cpu_hold, 1'h0, "wake end");
    wr(CTRL_OFFSET, 32'h00000061);
    repeat (40) @(posedge pclk);
    rd(CTRL_OFFSET, 32'h00000065, 32'hFFFFFFFF, 1'h0);
    $display("test crystal done");
    do_reset(MODE_XT, 1'h1, 1'h0);
    repeat (100) @(posedge pclk);
    chk(cpu_hold, 1'h0, "two speed");
    rd(CTRL_OFFSET, 32'h00000060, 32'hFFFFFFF9, 1'h0);
    $display("test two speed done");
    do_reset(MODE_EC, 1'h0, 1'h1);
    repeat (50) @(posedge pclk);
    chk(cpu_hold, 1'h0, "ec delay");
    rd(CTRL_OFFSET, 32'h00000068, 32'hFFFFFFF9, 1'h0);
    chk(clock_fail, 1'h0, "no fail");
    run <= 1'h0;
    repeat (FAILN + 40) @(posedge pclk);
    chk(clock_fail, 1'h1, "fail flag");
    rd(CTRL_OFFSET, 32'h00000060, 32'hFFFFFFF9, 1'h0);
    rd(STAT_OFFSET, 32'h00000001, 32'hFFFFFFFB, 1'h0);
    $display("test fail-safe done");
    repeat (5) @(posedge pclk);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
